// ==== core/atc_consts.svh ====
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

`define ATC_EA_W        32
`define ATC_BAT_N       4
`define ATC_BEPI_W      15
`define ATC_BMASK_W     11
`define ATC_TLB_SETS    32
`define ATC_TLB_WAYS    2
`define ATC_TLB_IDX_W   5
`define ATC_TLB_TAG_W   15
`define ATC_PPN_W       20
`define ATC_C_SETS      128
`define ATC_C_WAYS      4
`define ATC_C_IDX_W     7
`define ATC_C_TAG_W     20
`define ATC_C_AGE_RST   8'hE4

`endif

// ==== core/atc_pkg.sv ====
`include "atc_consts.svh"

package atc_pkg;

  typedef logic [`ATC_EA_W-1:0]    atc_addr_t;
  typedef logic [`ATC_PPN_W-1:0]   atc_ppn_t;
  typedef logic [`ATC_BEPI_W-1:0]  atc_bepi_t;
  typedef logic [`ATC_C_TAG_W-1:0] atc_ctag_t;

  typedef enum logic [1:0]
  {
    ATC_SRC_NONE = 2'b00,
    ATC_SRC_BAT  = 2'b01,
    ATC_SRC_TLB  = 2'b11
  } atc_src_e;

endpackage : atc_pkg

// ==== core/atc_lookup.sv ====
`timescale 1ns/100ps
`include "atc_consts.svh"

module atc_lookup
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  // Instruction side.
  input  wire logic                     i_req_valid_in,
  input  wire logic [31:0]              i_ea_in,
  input  wire logic                     i_bat_wr_in,
  input  wire logic [1:0]               i_bat_idx_in,
  input  wire logic                     i_bat_valid_in,
  input  wire logic [14:0]              i_bat_bepi_in,
  input  wire logic [10:0]              i_bat_mask_in,
  input  wire logic [14:0]              i_bat_brpn_in,
  input  wire logic                     i_tlb_fill_in,
  input  wire logic [31:0]              i_tlb_fill_ea_in,
  input  wire logic [19:0]              i_tlb_fill_ppn_in,
  input  wire logic                     i_cache_fill_in,
  input  wire logic [31:0]              i_cache_fill_pa_in,
  input  wire logic [1:0]               i_lock_ways_in,
  input  wire logic                     i_lock_all_in,
  output logic                          i_resp_valid_out,
  output logic [31:0]                   i_pa_out,
  output logic [1:0]                    i_src_out,
  output logic                          i_miss_out,
  output logic                          i_cache_hit_out,
  output logic [1:0]                    i_cache_way_out,
  output logic                          i_fill_done_out,
  // Data side.
  input  wire logic                     d_req_valid_in,
  input  wire logic [31:0]              d_ea_in,
  input  wire logic                     d_bat_wr_in,
  input  wire logic [1:0]               d_bat_idx_in,
  input  wire logic                     d_bat_valid_in,
  input  wire logic [14:0]              d_bat_bepi_in,
  input  wire logic [10:0]              d_bat_mask_in,
  input  wire logic [14:0]              d_bat_brpn_in,
  input  wire logic                     d_tlb_fill_in,
  input  wire logic [31:0]              d_tlb_fill_ea_in,
  input  wire logic [19:0]              d_tlb_fill_ppn_in,
  input  wire logic                     d_cache_fill_in,
  input  wire logic [31:0]              d_cache_fill_pa_in,
  input  wire logic [1:0]               d_lock_ways_in,
  input  wire logic                     d_lock_all_in,
  output logic                          d_resp_valid_out,
  output logic [31:0]                   d_pa_out,
  output logic [1:0]                    d_src_out,
  output logic                          d_miss_out,
  output logic                          d_cache_hit_out,
  output logic [1:0]                    d_cache_way_out,
  output logic                          d_fill_done_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Ways below the lock count are protected; lock_all protects every way.
  function automatic logic [3:0] lock_mask(input logic [1:0] n, input logic all);
    lock_mask = all ? 4'hF : 4'((5'h01 << n) - 5'h01);
  endfunction : lock_mask

  // Age 0 is most recent; touching a way ages every younger way by one.
  function automatic logic [7:0] age_touch(input logic [7:0] ages, input logic [1:0] w);
    logic [1:0] aw;
    aw = ages[w*2 +: 2];
    age_touch = ages;
    for (int k = 0; k < 4; k++)
    begin
      if (ages[k*2 +: 2] < aw)
      begin
        age_touch[k*2 +: 2] = ages[k*2 +: 2] + 2'd1;
      end
    end
    age_touch[w*2 +: 2] = 2'd0;
  endfunction : age_touch

  // ****************************************************************
  // Side fan-in
  // ****************************************************************

  logic [1:0]        req_v, bat_wr, bat_vin, tlb_fill, c_fill, lock_all;
  logic [1:0][31:0]  ea, tlb_fill_ea, c_fill_pa;
  logic [1:0][1:0]   bat_idx, lock_n;
  logic [1:0][14:0]  bat_bepi, bat_brpn;
  logic [1:0][10:0]  bat_mask;
  logic [1:0][19:0]  tlb_ppn;
  logic [1:0]        resp_q, miss_q, chit_q, fdone_q;
  logic [1:0][31:0]  pa_q;
  logic [1:0][1:0]   src_q, cway_q;

  assign req_v       = {d_req_valid_in, i_req_valid_in};
  assign ea          = {d_ea_in, i_ea_in};
  assign bat_wr      = {d_bat_wr_in, i_bat_wr_in};
  assign bat_vin     = {d_bat_valid_in, i_bat_valid_in};
  assign bat_idx     = {d_bat_idx_in, i_bat_idx_in};
  assign bat_bepi    = {d_bat_bepi_in, i_bat_bepi_in};
  assign bat_mask    = {d_bat_mask_in, i_bat_mask_in};
  assign bat_brpn    = {d_bat_brpn_in, i_bat_brpn_in};
  assign tlb_fill    = {d_tlb_fill_in, i_tlb_fill_in};
  assign tlb_fill_ea = {d_tlb_fill_ea_in, i_tlb_fill_ea_in};
  assign tlb_ppn     = {d_tlb_fill_ppn_in, i_tlb_fill_ppn_in};
  assign c_fill      = {d_cache_fill_in, i_cache_fill_in};
  assign c_fill_pa   = {d_cache_fill_pa_in, i_cache_fill_pa_in};
  assign lock_n      = {d_lock_ways_in, i_lock_ways_in};
  assign lock_all    = {d_lock_all_in, i_lock_all_in};

  // ****************************************************************
  // Per-side translation and cache lookup
  // ****************************************************************

  for (genvar g = 0; g < 2; g++)
  begin : g_side
    logic [14:0]  bepi_q [4];
    logic [10:0]  bmask_q [4];
    logic [14:0]  brpn_q [4];
    logic [3:0]   bv_q;
    logic [14:0]  ttag_q [32][2];
    logic [19:0]  tppn_q [32][2];
    logic [31:0][1:0] tv_q;
    logic [31:0]  tlru_q;
    logic [19:0]  ctag_q [128][4];
    logic [127:0][3:0] cv_q;
    logic [127:0][7:0] cage_q;

    logic [3:0]   bat_hit;
    logic         any_bat, any_tlb, tlb_way, c_hit, c_ok;
    logic [31:0]  pa;
    logic [1:0]   c_way, vic;
    logic [4:0]   tset, fset;
    logic [6:0]   cset, vset;
    logic [1:0]   t_hit;
    logic         tvic;
    logic [3:0]   lk;

    assign tset = ea[g][16:12];
    assign fset = tlb_fill_ea[g][16:12];
    assign lk   = lock_mask(lock_n[g], lock_all[g]);

    always_comb
    begin
      logic [14:0] m;
      m       = 15'h0000;
      bat_hit = 4'h0;
      any_bat = 1'b0;
      any_tlb = 1'b0;
      tlb_way = 1'b0;
      pa      = 32'h0000_0000;
      // Every entry is compared in the same cycle; lowest index wins a tie.
      for (int k = 3; k >= 0; k--)
      begin
        m = {4'h0, bmask_q[k]};
        bat_hit[k] = bv_q[k] && ((ea[g][31:17] & ~m) == (bepi_q[k] & ~m));
        if (bat_hit[k])
        begin
          pa = {(brpn_q[k] & ~m) | (ea[g][31:17] & m), ea[g][16:0]};
        end
      end
      any_bat = |bat_hit;
      for (int w = 0; w < 2; w++)
      begin
        t_hit[w] = tv_q[tset][w] && (ttag_q[tset][w] == ea[g][31:17]);
      end
      any_tlb = |t_hit;
      tlb_way = t_hit[1];
      if (!any_bat && any_tlb)
      begin
        pa = {tppn_q[tset][tlb_way], ea[g][11:0]};
      end
    end

    assign cset = pa[11:5];

    always_comb
    begin
      c_hit = 1'b0;
      c_way = 2'd0;
      for (int w = 0; w < 4; w++)
      begin
        if (cv_q[cset][w] && (ctag_q[cset][w] == pa[31:12]))
        begin
          c_hit = 1'b1;
          c_way = 2'(w);
        end
      end
    end

    // Victim choice skips locked ways; invalid ways go first, else the oldest.
    assign vset = c_fill_pa[g][11:5];
    always_comb
    begin
      logic [1:0] best;
      best = 2'd0;
      vic  = 2'd0;
      c_ok = 1'b0;
      for (int w = 3; w >= 0; w--)
      begin
        if (!lk[w] && (!c_ok || cage_q[vset][w*2 +: 2] >= best))
        begin
          c_ok = 1'b1;
          vic  = 2'(w);
          best = cage_q[vset][w*2 +: 2];
        end
      end
      for (int w = 3; w >= 0; w--)
      begin
        if (!lk[w] && !cv_q[vset][w])
        begin
          vic = 2'(w);
        end
      end
    end

    assign tvic = !tv_q[fset][0] ? 1'b0 : (!tv_q[fset][1] ? 1'b1 : tlru_q[fset]);

    // ****************************************************************
    // Block translation array
    // ****************************************************************

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        bv_q <= 4'h0;
      end
      else if (bat_wr[g])
      begin
        bv_q[bat_idx[g]] <= bat_vin[g];
      end
    end

    always_ff @(posedge sys_clk_in)
    begin
      if (bat_wr[g])
      begin
        bepi_q[bat_idx[g]]  <= bat_bepi[g];
        bmask_q[bat_idx[g]] <= bat_mask[g];
        brpn_q[bat_idx[g]]  <= bat_brpn[g];
      end
    end

    // ****************************************************************
    // Lookaside buffer
    // ****************************************************************

    always_ff @(posedge sys_clk_in)
    begin
      if (tlb_fill[g])
      begin
        ttag_q[fset][tvic] <= tlb_fill_ea[g][31:17];
        tppn_q[fset][tvic] <= tlb_ppn[g];
      end
    end

    // A refill in the same cycle as a hit in its set takes the replacement bit.
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        tv_q   <= '0;
        tlru_q <= 32'h0000_0000;
      end
      else
      begin
        if (req_v[g] && any_tlb && !any_bat)
        begin
          tlru_q[tset] <= ~tlb_way;
        end
        if (tlb_fill[g])
        begin
          tv_q[fset][tvic] <= 1'b1;
          tlru_q[fset]     <= ~tvic;
        end
      end
    end

    // ****************************************************************
    // Cache tags and ages
    // ****************************************************************

    always_ff @(posedge sys_clk_in)
    begin
      if (c_fill[g] && c_ok)
      begin
        ctag_q[vset][vic] <= c_fill_pa[g][31:12];
      end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        cv_q   <= '0;
        cage_q <= {128{`ATC_C_AGE_RST}};
      end
      else
      begin
        if (req_v[g] && (any_bat || any_tlb) && c_hit)
        begin
          cage_q[cset] <= age_touch(cage_q[cset], c_way);
        end
        if (c_fill[g] && c_ok)
        begin
          cv_q[vset][vic] <= 1'b1;
          cage_q[vset]    <= age_touch(cage_q[vset], vic);
        end
      end
    end

    // ****************************************************************
    // Response
    // ****************************************************************

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        resp_q[g]  <= 1'b0;
        pa_q[g]    <= 32'h0000_0000;
        src_q[g]   <= atc_pkg::ATC_SRC_NONE;
        miss_q[g]  <= 1'b0;
        chit_q[g]  <= 1'b0;
        cway_q[g]  <= 2'd0;
        fdone_q[g] <= 1'b0;
      end
      else
      begin
        resp_q[g]  <= req_v[g];
        fdone_q[g] <= c_fill[g] && c_ok;
        if (req_v[g])
        begin
          pa_q[g]   <= pa;
          src_q[g]  <= any_bat ? atc_pkg::ATC_SRC_BAT :
                       (any_tlb ? atc_pkg::ATC_SRC_TLB : atc_pkg::ATC_SRC_NONE);
          miss_q[g] <= !any_bat && !any_tlb;
          chit_q[g] <= (any_bat || any_tlb) && c_hit;
          cway_q[g] <= (any_bat || any_tlb) ? c_way : 2'd0;
        end
      end
    end
  end

  assign i_resp_valid_out = resp_q[0];
  assign i_pa_out         = pa_q[0];
  assign i_src_out        = src_q[0];
  assign i_miss_out       = miss_q[0];
  assign i_cache_hit_out  = chit_q[0];
  assign i_cache_way_out  = cway_q[0];
  assign i_fill_done_out  = fdone_q[0];
  assign d_resp_valid_out = resp_q[1];
  assign d_pa_out         = pa_q[1];
  assign d_src_out        = src_q[1];
  assign d_miss_out       = miss_q[1];
  assign d_cache_hit_out  = chit_q[1];
  assign d_cache_way_out  = cway_q[1];
  assign d_fill_done_out  = fdone_q[1];

endmodule : atc_lookup

// ==== bench/atc_lookup_checker.sv ====
`timescale 1ns/100ps
module atc_lookup_checker
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        i_req_valid_in,
  input  wire logic        i_resp_valid_out,
  input  wire logic        i_miss_out,
  input  wire logic [1:0]  i_src_out,
  input  wire logic [31:0] i_pa_out,
  input  wire logic        i_cache_hit_out,
  input  wire logic        i_cache_fill_in,
  input  wire logic        i_lock_all_in,
  input  wire logic        i_fill_done_out,
  input  wire logic        d_req_valid_in,
  input  wire logic        d_resp_valid_out,
  input  wire logic        d_miss_out,
  input  wire logic        d_cache_hit_out,
  input  wire logic        d_cache_fill_in,
  input  wire logic        d_lock_all_in,
  input  wire logic        d_fill_done_out
);
  // ****************
  // Port properties
  // ****************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_i_resp_lat : assert property (i_req_valid_in |=> i_resp_valid_out)
    else $error("instruction response not one cycle after request");
  a_i_resp_cause : assert property (i_resp_valid_out |-> $past(i_req_valid_in))
    else $error("instruction response without request");
  a_i_miss_clean : assert property (i_resp_valid_out && i_miss_out |->
    i_src_out == 2'b00 && i_pa_out == 32'h0000_0000 && !i_cache_hit_out)
    else $error("instruction miss reported a translation or cache hit");
  a_i_hit_src : assert property (i_resp_valid_out && !i_miss_out |-> i_src_out != 2'b00)
    else $error("instruction hit without a source");
  a_i_lock_all : assert property (i_fill_done_out |->
    $past(i_cache_fill_in) && !$past(i_lock_all_in))
    else $error("instruction fill done while fully locked");
  a_d_resp_lat : assert property (d_req_valid_in |=> d_resp_valid_out)
    else $error("data response not one cycle after request");
  a_d_miss_clean : assert property (d_resp_valid_out && d_miss_out |-> !d_cache_hit_out)
    else $error("data miss reported a cache hit");
  a_d_lock_all : assert property (d_fill_done_out |->
    $past(d_cache_fill_in) && !$past(d_lock_all_in))
    else $error("data fill done while fully locked");
  c_i_miss : cover property (i_resp_valid_out && i_miss_out);
  c_i_hit : cover property (i_resp_valid_out && i_cache_hit_out);
  c_d_fill : cover property (d_fill_done_out);
endmodule : atc_lookup_checker

// ==== bench/atc_core_model.sv ====
`timescale 1ns/100ps
module atc_core_model
(
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [31:0] ea_in,
  output logic             req_out,
  output logic [31:0]      ea_out
);
  // ****************
  // Request driver
  // ****************
  logic        req_q = 1'b0;
  logic [31:0] ea_q  = 32'h0000_0000;
  // Between requests the address toggles, so a stale value never passes for a live one.
  always @(posedge clk_in)
  begin
    req_q <= go_in;
    ea_q  <= go_in ? ea_in : ~ea_q;
  end
  assign req_out = req_q;
  assign ea_out  = ea_q;
endmodule : atc_core_model

// ==== bench/test_address_translation_cache_lookup.sv ====
`timescale 1ns/100ps
module test_address_translation_cache_lookup;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        go, i_req_valid_in, d_req_valid_in, i_bat_wr_in, d_bat_wr_in;
  logic        i_bat_valid_in, d_bat_valid_in, i_tlb_fill_in, d_tlb_fill_in;
  logic        i_cache_fill_in, d_cache_fill_in, i_lock_all_in, d_lock_all_in;
  logic [1:0]  i_bat_idx_in, d_bat_idx_in, i_lock_ways_in, d_lock_ways_in;
  logic [14:0] i_bat_bepi_in, d_bat_bepi_in, i_bat_brpn_in, d_bat_brpn_in;
  logic [10:0] i_bat_mask_in, d_bat_mask_in;
  logic [31:0] ea_r, i_ea_in, d_ea_in, i_tlb_fill_ea_in, d_tlb_fill_ea_in;
  logic [31:0] i_cache_fill_pa_in, d_cache_fill_pa_in, i_pa_out, d_pa_out;
  logic [19:0] i_tlb_fill_ppn_in, d_tlb_fill_ppn_in;
  logic        i_resp_valid_out, i_miss_out, i_cache_hit_out, i_fill_done_out;
  logic        d_resp_valid_out, d_miss_out, d_cache_hit_out, d_fill_done_out;
  logic [1:0]  i_src_out, d_src_out, i_cache_way_out, d_cache_way_out;
  int          mismatches = 0;
  int          checks     = 0;

  always #5 sys_clk_in = ~sys_clk_in;
  atc_lookup uut (.*);
  atc_core_model im (.clk_in(sys_clk_in), .go_in(go), .ea_in(ea_r), .req_out(i_req_valid_in),
                     .ea_out(i_ea_in));
  atc_core_model dm (.clk_in(sys_clk_in), .go_in(go), .ea_in(ea_r), .req_out(d_req_valid_in),
                     .ea_out(d_ea_in));

  // ****************
  // Shared tasks
  // ****************
  task automatic close_out;
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Both sides get the same request, so each is checked against the same expectation.
  task automatic look(input logic [31:0] ea, input logic [1:0] src, input logic [31:0] pa,
                      input logic hit, input logic [1:0] way);
    int n = 0;
    @(posedge sys_clk_in);
    go   <= 1'b1;
    ea_r <= ea;
    @(posedge sys_clk_in);
    go <= 1'b0;
    while (!(i_resp_valid_out === 1'b1 && d_resp_valid_out === 1'b1) && n < 4)
    begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk({i_resp_valid_out, d_resp_valid_out}, 2'b11);
    chk({i_src_out, i_miss_out, i_cache_hit_out, i_cache_way_out}, {src, src == 2'b00, hit, way});
    chk({d_src_out, d_miss_out, d_cache_hit_out, d_cache_way_out}, {src, src == 2'b00, hit, way});
    chk(i_pa_out, pa);
    chk(d_pa_out, pa);
  endtask : look

  task automatic tlb(input logic [31:0] ea, input logic [19:0] ppn);
    @(posedge sys_clk_in);
    {i_tlb_fill_in, d_tlb_fill_in} <= 2'b11;
    {i_tlb_fill_ea_in, d_tlb_fill_ea_in} <= {ea, ea};
    {i_tlb_fill_ppn_in, d_tlb_fill_ppn_in} <= {ppn, ppn};
    @(posedge sys_clk_in);
    {i_tlb_fill_in, d_tlb_fill_in} <= 2'b00;
  endtask : tlb

  task automatic block_translation_array(input logic [1:0] idx, input logic [14:0] bepi, input logic [10:0] mask,
                     input logic [14:0] brpn);
    @(posedge sys_clk_in);
    {i_bat_wr_in, d_bat_wr_in, i_bat_valid_in, d_bat_valid_in} <= 4'b1111;
    {i_bat_idx_in, d_bat_idx_in} <= {idx, idx};
    {i_bat_bepi_in, d_bat_bepi_in, i_bat_brpn_in, d_bat_brpn_in} <= {bepi, bepi, brpn, brpn};
    {i_bat_mask_in, d_bat_mask_in} <= {mask, mask};
    @(posedge sys_clk_in);
    {i_bat_wr_in, d_bat_wr_in} <= 2'b00;
  endtask : block_translation_array

  task automatic fill(input logic [31:0] pa, input logic done, input logic [1:0] ways,
                      input logic all);
    @(posedge sys_clk_in);
    {i_cache_fill_in, d_cache_fill_in} <= 2'b11;
    {i_cache_fill_pa_in, d_cache_fill_pa_in} <= {pa, pa};
    {i_lock_ways_in, d_lock_ways_in, i_lock_all_in, d_lock_all_in} <= {ways, ways, all, all};
    @(posedge sys_clk_in);
    {i_cache_fill_in, d_cache_fill_in} <= 2'b00;
    #1;
    chk({i_fill_done_out, d_fill_done_out}, {done, done});
  endtask : fill

  // ****************
  // Scenarios
  // ****************
  task automatic t_tlb;
    look(32'h1234_5678, 2'b00, 32'h0000_0000, 1'b0, 2'd0);
    tlb(32'h0000_1000, 20'h0_0AAA);
    tlb(32'h0002_1000, 20'h0_0BBB);
    look(32'h0002_1FFC, 2'b11, 32'h00BB_BFFC, 1'b0, 2'd0);
    look(32'h0000_1234, 2'b11, 32'h00AA_A234, 1'b0, 2'd0);
    tlb(32'h0004_1000, 20'h0_0CCC);
    look(32'h0002_1000, 2'b00, 32'h0000_0000, 1'b0, 2'd0);
    look(32'h0000_1000, 2'b11, 32'h00AA_A000, 1'b0, 2'd0);
    look(32'h0004_1010, 2'b11, 32'h00CC_C010, 1'b0, 2'd0);
  endtask : t_tlb

  task automatic t_bat;
    block_translation_array(2'd2, 15'h0000, 11'h000, 15'h4000);
    block_translation_array(2'd3, 15'h0010, 11'h001, 15'h0020);
    look(32'h0000_1234, 2'b01, 32'h8000_1234, 1'b0, 2'd0);
    look(32'h0022_0040, 2'b01, 32'h0042_0040, 1'b0, 2'd0);
    look(32'h0020_0040, 2'b01, 32'h0040_0040, 1'b0, 2'd0);
    // Entries 1 and 3 now both match this page; the lower index must supply the address.
    block_translation_array(2'd1, 15'h0010, 11'h000, 15'h0030);
    look(32'h0020_0040, 2'b01, 32'h0060_0040, 1'b0, 2'd0);
  endtask : t_bat

  task automatic t_cache;
    for (int k = 0; k < 4; k++)
      fill(32'h8000_0000 + (k << 12), 1'b1, 2'd0, 1'b0);
    for (int k = 0; k < 4; k++)
      look(k << 12, 2'b01, 32'h8000_0000 + (k << 12), 1'b1, k[1:0]);
    look(32'h0000_0000, 2'b01, 32'h8000_0000, 1'b1, 2'd0);
    fill(32'h8000_4000, 1'b1, 2'd0, 1'b0);
    look(32'h0000_1000, 2'b01, 32'h8000_1000, 1'b0, 2'd0);
    look(32'h0000_4000, 2'b01, 32'h8000_4000, 1'b1, 2'd1);
    fill(32'h8000_5000, 1'b1, 2'd3, 1'b0);
    look(32'h0000_5000, 2'b01, 32'h8000_5000, 1'b1, 2'd3);
    fill(32'h8000_6000, 1'b0, 2'd0, 1'b1);
    look(32'h0000_6000, 2'b01, 32'h8000_6000, 1'b0, 2'd0);
    // A line at physical zero would hit on a miss's zero address if the cache were not withheld.
    fill(32'h0000_0000, 1'b1, 2'd0, 1'b0);
    look(32'h1234_5678, 2'b00, 32'h0000_0000, 1'b0, 2'd0);
  endtask : t_cache

  initial
  begin
    {go, ea_r, i_bat_wr_in, d_bat_wr_in, i_bat_valid_in, d_bat_valid_in, i_tlb_fill_in,
     d_tlb_fill_in, i_cache_fill_in, d_cache_fill_in, i_lock_all_in, d_lock_all_in,
     i_bat_idx_in, d_bat_idx_in, i_lock_ways_in, d_lock_ways_in, i_bat_bepi_in, d_bat_bepi_in,
     i_bat_brpn_in, d_bat_brpn_in, i_bat_mask_in, d_bat_mask_in, i_tlb_fill_ea_in,
     d_tlb_fill_ea_in, i_cache_fill_pa_in, d_cache_fill_pa_in, i_tlb_fill_ppn_in,
     d_tlb_fill_ppn_in} = '0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_tlb();
    t_bat();
    t_cache();
    close_out();
  end

  // The whole run needs about ninety cycles; this bound only cuts a hang short.
  initial
  begin
    repeat (3000) @(posedge sys_clk_in);
    mismatches++;
    close_out();
  end
endmodule : test_address_translation_cache_lookup

bind atc_lookup atc_lookup_checker chk (.*);
